// ===== hdl/sep_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - read data leaves on the output pin at falling clock edges, msb first
// - output pin is high impedance whenever no read is shifting out
// - input pin is sampled on each rising clock edge, msb first
// - device is selected only while the active-low select is low
// - select high deselects and releases the output at once
// - pause low suspends transfer without deselecting; it resumes afterwards
// - write-protect pin low plus srwd set blocks status register writes
// - array holds 65536 bytes as 512 pages of 128, byte addressed
// - array data is guarded by internal error correction, invisible outside
// - separate 128-byte identification page readable by the master
// - identification page writable until locked, then read-only until reset
// - clock may idle low or high; rising samples, falling shifts
// - pause starts and ends only while clock low; inputs ignored meanwhile
// - select rising during pause abandons the paused transfer
// - after power-up nothing starts until a falling edge on select
module sep_core
  import sep_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // serial pins
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic pause_n,
  input wire logic wprot_n,
  output logic sdo,
  output logic sdo_oe,
  // status
  output logic busy_sel,
  output logic id_locked
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  // async assert, release only on a clock edge
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_i_n = rst_sync_r;

  // one bank for all five pins; ce freezes it too
  wire [4:0] pin_s;
  sep_pin_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst_n(rst_i_n),
    .ce(ce),
    .pin_in({sclk, sel_n, sdi, pause_n, wprot_n}),
    .pin_reset_val(5'h1F),
    .pin_sync(pin_s)
  );
  wire sclk_s = pin_s[4];
  wire sel_n_s = pin_s[3];
  wire sdi_s = pin_s[2];
  wire pause_n_s = pin_s[1];
  wire wprot_n_s = pin_s[0];

  //////////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised pins
  logic sclk_d_r;
  logic sel_d_r;
  logic armed_r;
  logic paused_r;
  logic [1:0] warm_r;
  wire sel_fall = sel_d_r && !sel_n_s;
  // synchronisers reset high, not to the pin; a low select at release must not read as a fall
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b0; // power-up: low select is not a falling edge
      armed_r <= 1'b0;
      warm_r <= 2'h0;
    end else if (ce) begin
      warm_r <= {warm_r[0], 1'b1};
      sclk_d_r <= sclk_s;
      sel_d_r <= warm_r[1] && sel_n_s;
      if (sel_fall) begin
        armed_r <= 1'b1;
      end else if (sel_n_s) begin
        armed_r <= 1'b0;
      end
    end
  end
  wire selected = armed_r && !sel_n_s;
  // rising and falling look the same in both idle polarities
  wire sck_rise = sclk_s && !sclk_d_r;
  wire sck_fall = !sclk_s && sclk_d_r;
  wire active = selected && !paused_r;
  wire bit_in = active && sck_rise;
  wire bit_out = active && sck_fall;

  // pause only changes while clock low; clock edges are ignored meanwhile
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      paused_r <= 1'b0;
    end else if (ce) begin
      if (!selected) begin
        paused_r <= 1'b0;
      end else if (!sclk_s) begin
        paused_r <= !pause_n_s;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // storage: main array with ecc, id page, status bits
  logic [7:0] idpage [ID_BYTES];
  logic [7:0] sr_r;
  logic lock_r;
  logic [ADDR_W-1:0] addr_r;
  wire [7:0] arr_q;
  logic arr_we;
  logic [7:0] shin_r;
  wire [7:0] byte_in = {shin_r[6:0], sdi_s};

  sep_ecc_mem #(.DEPTH(ARRAY_BYTES), .AW(ADDR_W)) u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(arr_we),
    .wr_addr(addr_r),
    .wr_data(byte_in),
    .rd_addr(addr_r),
    .rd_data(arr_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // command decoder
  // partial bytes die with the select
  sep_state_type state_r;
  sep_state_type state_nxt;
  logic [7:0] cmd_r;
  logic [2:0] bitcnt_r;
  logic addr_hi_r;
  logic [7:0] shout_r;
  logic out_en_r;

  wire byte_done = bit_in && (bitcnt_r == 3'h7);
  wire [ADDR_W-1:0] addr_full = {addr_r[7:0], byte_in};
  wire [ADDR_W-1:0] addr_inc = addr_r + 16'h0001;
  wire [ADDR_W-1:0] addr_wrap = {addr_r[ADDR_W-1:PAGE_ADDR_W], addr_inc[PAGE_ADDR_W-1:0]};
  wire is_read = (cmd_r == CMD_READ) || (cmd_r == CMD_RDID) || (cmd_r == CMD_RDSR);
  wire wel = sr_r[SR_WEL_BIT];
  wire [1:0] bp = {sr_r[SR_BP1_BIT], sr_r[SR_BP0_BIT]};
  wire sr_locked = sr_r[SR_SRWD_BIT] && !wprot_n_s;
  // block protect: upper quarter, upper half or whole array
  wire prot_quarter = (bp == 2'h1) && (addr_r[15:14] == 2'h3);
  wire prot_half = (bp == 2'h2) && addr_r[15];
  wire prot_whole = (bp == 2'h3);
  wire blk_prot = prot_whole || prot_half || prot_quarter;
  wire id_lock_req = addr_r[ID_LOCK_ADDR_BIT];
  wire [7:0] id_q = id_lock_req ? {7'h00, lock_r} : idpage[addr_r[PAGE_ADDR_W-1:0]];
  wire [7:0] rd_byte = (cmd_r == CMD_RDSR) ? sr_r : (cmd_r == CMD_RDID) ? id_q : arr_q;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SEP_IDLE: state_nxt = selected ? SEP_CMD : SEP_IDLE;
      SEP_CMD: begin
        if (byte_done) begin
          case (byte_in)
            CMD_READ, CMD_WRITE, CMD_RDID, CMD_WRID: state_nxt = SEP_ADDR;
            CMD_RDSR: state_nxt = SEP_RDATA;
            CMD_WRSR: state_nxt = SEP_WDATA;
            default: state_nxt = SEP_IGNORE;
          endcase
        end
      end
      SEP_ADDR: begin
        if (byte_done && addr_hi_r) begin
          state_nxt = is_read ? SEP_RDATA : SEP_WDATA;
        end
      end
      SEP_WDATA: state_nxt = SEP_WDATA;
      SEP_RDATA: state_nxt = SEP_RDATA;
      SEP_IGNORE: state_nxt = SEP_IGNORE;
      default: state_nxt = SEP_IDLE;
    endcase
    if (!selected) begin
      state_nxt = SEP_IDLE;
    end
  end

  // one full data byte of the given write command has just arrived
  function automatic logic wr_byte(input sep_state_type st, input logic done, input logic [7:0] cmd,
    input logic [7:0] code);
    return (st == SEP_WDATA) && done && (cmd == code);
  endfunction

  // write strobes for array, id page and status register, gated by latch and block, lock or srwd protection
  assign arr_we = wr_byte(state_r, byte_done, cmd_r, CMD_WRITE) && wel && !blk_prot;
  wire id_we = wr_byte(state_r, byte_done, cmd_r, CMD_WRID) && wel && !lock_r && !prot_whole;
  wire sr_we = wr_byte(state_r, byte_done, cmd_r, CMD_WRSR) && wel && !sr_locked;
  wire cmd_take = (state_r == SEP_CMD) && byte_done;

  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      state_r <= SEP_IDLE;
      cmd_r <= 8'h00;
      bitcnt_r <= 3'h0;
      addr_hi_r <= 1'b0;
      shin_r <= 8'h00;
      addr_r <= 16'h0000;
    end else if (ce) begin
      state_r <= state_nxt;
      if (!selected) begin
        bitcnt_r <= 3'h0;
        addr_hi_r <= 1'b0;
      end else if (bit_in) begin
        bitcnt_r <= bitcnt_r + 3'h1;
        shin_r <= byte_in;
      end
      if (cmd_take) begin
        cmd_r <= byte_in;
      end
      if (state_r == SEP_ADDR && byte_done) begin
        addr_r <= addr_full;
        addr_hi_r <= 1'b1;
      end else if ((state_r == SEP_WDATA || state_r == SEP_RDATA) && byte_done) begin
        addr_r <= (cmd_r == CMD_READ) ? addr_inc : addr_wrap; // writes roll within page
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status register, id page and lock; write cycle time not modelled
  // wel drops after each written byte, not at frame end
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      sr_r <= SR_RESET;
      lock_r <= 1'b0;
    end else if (ce) begin
      if (cmd_take && byte_in == CMD_WREN) begin
        sr_r[SR_WEL_BIT] <= 1'b1;
      end else if (cmd_take && byte_in == CMD_WRDI) begin
        sr_r[SR_WEL_BIT] <= 1'b0;
      end else if (sr_we) begin
        sr_r <= byte_in & SR_WRITABLE_MASK;
      end else if (arr_we || id_we) begin
        sr_r[SR_WEL_BIT] <= 1'b0;
      end
      if (id_we && id_lock_req) begin
        lock_r <= 1'b1;
      end
    end
  end

  // id page kept apart from the ecc array; no correction here
  always_ff @(posedge clk) begin
    if (ce && id_we && !id_lock_req) begin
      idpage[addr_r[PAGE_ADDR_W-1:0]] <= byte_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output shifter: first bit goes out on the falling edge after the last address bit, or after the last instruction bit for RDSR
  wire load_out = (state_r == SEP_RDATA) ? (bit_out && bitcnt_r == 3'h0) :
    ((state_nxt == SEP_RDATA) && (state_r != SEP_RDATA));
  // output driven only mid-read, selected and not paused
  wire drive_ok = selected && out_en_r && !paused_r && (state_r == SEP_RDATA);
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      shout_r <= 8'h00;
      out_en_r <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      busy_sel <= 1'b0;
      id_locked <= 1'b0;
    end else if (ce) begin
      busy_sel <= selected;
      id_locked <= lock_r;
      if (!selected) begin
        out_en_r <= 1'b0;
      end else if (load_out && state_r != SEP_RDATA) begin
        shout_r <= rd_byte;
        out_en_r <= 1'b1;
      end else if (bit_out && state_r == SEP_RDATA) begin
        sdo <= shout_r[7];
        shout_r <= (bitcnt_r == 3'h0) ? rd_byte : {shout_r[6:0], 1'b0};
      end
      if (bit_out && state_r == SEP_RDATA && bitcnt_r == 3'h0) begin
        sdo <= rd_byte[7];
        shout_r <= {rd_byte[6:0], 1'b0};
      end
      sdo_oe <= drive_ok;
    end
  end

endmodule

// ===== hdl/sep_pkg.sv
package sep_pkg;

  // array geometry
  localparam int ARRAY_BYTES = 65536;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_COUNT = 512;
  localparam int ADDR_W = 16;
  localparam int PAGE_ADDR_W = 7;
  localparam int ID_BYTES = 128;

  // instruction codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_RDID = 8'h83;
  localparam logic [7:0] CMD_WRID = 8'h82;

  // status register fields
  localparam int SR_WEL_BIT = 1;
  localparam int SR_BP0_BIT = 2;
  localparam int SR_BP1_BIT = 3;
  localparam int SR_SRWD_BIT = 7;
  localparam logic [7:0] SR_WRITABLE_MASK = 8'h8C;
  localparam logic [7:0] SR_RESET = 8'h00;

  // identification page lock address bit (address bit 10 set selects lock)
  localparam int ID_LOCK_ADDR_BIT = 10;

  // ecc: hamming over 8 data bits, 4 check bits
  localparam int ECC_W = 4;

  typedef enum logic [2:0] {
    SEP_IDLE = 3'b000,
    SEP_CMD = 3'b001,
    SEP_ADDR = 3'b010,
    SEP_WDATA = 3'b011,
    SEP_RDATA = 3'b100,
    SEP_IGNORE = 3'b101
  } sep_state_type;

endpackage

// ===== hdl/sep_ecc_mem.sv
`timescale 1ns/1ps
module sep_ecc_mem
  import sep_pkg::*;
#(
  parameter int DEPTH = ARRAY_BYTES,
  parameter int AW = ADDR_W
) (
  // clock
  input wire logic clk,
  input wire logic ce,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port, combinational, corrected
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [ECC_W-1:0] ecc_gen(input logic [7:0] d);
    ecc_gen[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    ecc_gen[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    ecc_gen[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
    ecc_gen[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
  endfunction

  // no init: array content is undefined like a fresh part
  logic [ECC_W+7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= {ecc_gen(wr_data), wr_data};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // single-bit correction of the data bits, hidden from the serial side
  wire [ECC_W+7:0] word = mem[rd_addr];
  wire [ECC_W-1:0] syn = ecc_gen(word[7:0]) ^ word[ECC_W+7:8];
  logic [7:0] flip;
  always_comb begin
    case (syn)
      4'h3: flip = 8'h01;
      4'h5: flip = 8'h02;
      4'h6: flip = 8'h04;
      4'h7: flip = 8'h08;
      4'h9: flip = 8'h10;
      4'hA: flip = 8'h20;
      4'hB: flip = 8'h40;
      4'hC: flip = 8'h80;
      default: flip = 8'h00;
    endcase
  end
  assign rd_data = word[7:0] ^ flip;

endmodule

// ===== hdl/sep_pin_sync.sv
`timescale 1ns/1ps
module sep_pin_sync
  import sep_pkg::*;
#(
  parameter int W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // pins in, synchronised out
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] pin_reset_val,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // reset value is constant per bit position at the instance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      sync_r <= '1;
    end else if (ce) begin
      meta_r <= pin_in;
      sync_r <= meta_r;
    end
  end

  assign pin_sync = sync_r ^ ~pin_reset_val;

endmodule

// ===== verification/sep_core_props.sv
`timescale 1ns/1ps
module sep_core_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // serial pins
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdi,
  input wire logic pause_n,
  input wire logic wprot_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  // status
  input wire logic busy_sel,
  input wire logic id_locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // eight cycles leaves the pin synchronisers time to settle
  sequence desel_held; sel_n [*8]; endsequence
  sequence paused_low; (!pause_n && !sclk) [*8]; endsequence
  sequence high_phase; $rose(sclk) ##1 (sclk && sdo_oe) [*2]; endsequence
  a_desel_release: assert property (desel_held |-> !sdo_oe) else $error("sdo driven while deselected");
  a_desel_idle: assert property (desel_held |-> !busy_sel) else $error("selected while select high");
  a_sel_start: assert property ($fell(sel_n) |-> ##[2:10] busy_sel) else $error("select fall not taken");
  a_out_needs_sel: assert property (sdo_oe |-> busy_sel) else $error("sdo driven while idle");
  a_out_steady: assert property (high_phase |-> $stable(sdo)) else $error("sdo moved in high phase");
  a_pause_float: assert property (paused_low |-> !sdo_oe) else $error("sdo driven in pause");
  a_pause_keeps: assert property (busy_sel && !pause_n && !sel_n |=> busy_sel) else $error("pause deselected");
  a_lock_sticky: assert property (id_locked |=> id_locked) else $error("id lock dropped");
endmodule
bind sep_core sep_core_props props_u (.clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .sel_n(sel_n), .sdi(sdi),
  .pause_n(pause_n), .wprot_n(wprot_n), .sdo(sdo), .sdo_oe(sdo_oe), .busy_sel(busy_sel), .id_locked(id_locked));

// ===== verification/sep_master_model.sv
`timescale 1ns/1ps
module sep_master_model #(
  parameter int HALF = 4
) (
  // clock and returned data
  input wire logic clk,
  input wire logic sdo_line,
  // pins toward the device
  output logic sclk,
  output logic sel_n,
  output logic sdi,
  output logic pause_n
);
  logic cpol;
  // select low from power-up on purpose
  initial begin
    sclk = 1'b0;
    sel_n = 1'b0;
    sdi = 1'b0;
    pause_n = 1'b1;
    cpol = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic begin_frame();
    sclk <= cpol;
    tick(HALF);
    sel_n <= 1'b0;
    tick(HALF);
  endtask
  // sample two cycles after rising: clear of both edges' updates
  task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk <= 1'b0;
      sdi <= tx[i];
      tick(HALF);
      sclk <= 1'b1;
      tick(2);
      rx[i] = sdo_line;
      tick(HALF - 2);
    end
  endtask
  task automatic hold_on();
    sclk <= 1'b0;
    tick(HALF);
    pause_n <= 1'b0;
    tick(10);
    sclk <= 1'b1;
    sdi <= ~sdi;
    tick(HALF);
    sclk <= 1'b0;
    tick(HALF);
  endtask
  task automatic hold_off();
    pause_n <= 1'b1;
    tick(HALF);
  endtask
  // released data line toggles so a stale bit is never trusted
  task automatic end_frame();
    sclk <= cpol;
    tick(HALF);
    sel_n <= 1'b1;
    tick(HALF);
    pause_n <= 1'b1;
    sdi <= ~sdi;
    tick(HALF + 2);
  endtask
endmodule

// ===== verification/spi_eeprom_serial_port_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module spi_eeprom_serial_port_tb;
  import sep_pkg::*;
  logic clk, rst_n, ce, wprot_n, sdo, sdo_oe, busy_sel, id_locked, sclk, sel_n, sdi, pause_n;
  wire sdo_line;
  int failures = 0;
  int n_compared = 0;
  int seed = 32'he33272f8;
  logic [7:0] rb [4];
  logic [7:0] wb [4];
  logic [7:0] mem [logic [15:0]];
  logic [7:0] t;
  logic [7:0] rx;
  logic [15:0] a;
  assign sdo_line = sdo_oe ? sdo : 1'bz;
  sep_core dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .sel_n(sel_n), .sdi(sdi), .pause_n(pause_n),
    .wprot_n(wprot_n), .sdo(sdo), .sdo_oe(sdo_oe), .busy_sel(busy_sel), .id_locked(id_locked));
  sep_master_model #(.HALF(4)) m_u (.clk(clk), .sdo_line(sdo_line), .sclk(sclk), .sel_n(sel_n), .sdi(sdi),
    .pause_n(pause_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [7:0] sr_exp(input logic [7:0] w, input logic wel);
    return (w & SR_WRITABLE_MASK) | {6'h00, wel, 1'b0};
  endfunction
  task automatic frame(input logic [7:0] op, input logic [15:0] ad, input bit has_a, input int n);
    m_u.begin_frame();
    m_u.shift(8, op, rx);
    if (has_a) begin
      m_u.shift(8, ad[15:8], rx);
      m_u.shift(8, ad[7:0], rx);
    end
    for (int i = 0; i < n; i++) begin
      m_u.shift(8, wb[i], rx);
      rb[i] = rx;
    end
    m_u.end_frame();
  endtask
  task automatic wr(input logic [7:0] op, input logic [15:0] ad, input bit has_a, input logic [7:0] d);
    frame(CMD_WREN, 16'h0000, 0, 0);
    wb[0] = d;
    frame(op, ad, has_a, 1);
  endtask
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    failures++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wprot_n = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK(busy_sel, 1'b0)
    m_u.end_frame();
    $display("test power-up done");
    // page end corner first, then random spots, both clock idles
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'h007F : 16'($random(seed)) & 16'hFFFE;
      m_u.cpol = i[0];
      for (int k = 0; k < 2; k++) begin
        t = 8'($random(seed));
        mem[a + 16'(k)] = t;
        wr(CMD_WRITE, a + 16'(k), 1, t);
        wb[k] = 8'($random(seed));
      end
      frame(CMD_READ, a, 1, 2);
      `CHK(rb[0], mem[a])
      `CHK(rb[1], mem[a + 16'h0001])
      `CHK(sdo_oe, 1'b0)
    end
    $display("test array done");
    wr(CMD_WRSR, 16'h0000, 0, 8'h80);
    wprot_n <= 1'b0;
    wr(CMD_WRSR, 16'h0000, 0, 8'h0C);
    frame(CMD_WRDI, 16'h0000, 0, 0);
    frame(CMD_RDSR, 16'h0000, 0, 1);
    `CHK(rb[0], sr_exp(8'h80, 1'b0))
    wprot_n <= 1'b1;
    t = 8'($random(seed));
    wr(CMD_WRITE, 16'hFF00, 1, t);
    wr(CMD_WRSR, 16'h0000, 0, 8'h08);
    wr(CMD_WRITE, 16'hFF00, 1, ~t);
    frame(CMD_READ, 16'hFF00, 1, 1);
    `CHK(rb[0], t)
    wr(CMD_WRSR, 16'h0000, 0, 8'h00);
    frame(CMD_WREN, 16'h0000, 0, 0);
    frame(CMD_RDSR, 16'h0000, 0, 1);
    `CHK(rb[0], sr_exp(8'h00, 1'b1))
    $display("test status done");
    m_u.begin_frame();
    m_u.shift(8, CMD_READ, rx);
    m_u.shift(8, a[15:8], rx);
    m_u.shift(8, a[7:0], rx);
    m_u.shift(8, 8'h00, rx);
    m_u.hold_on();
    `CHK(sdo_oe, 1'b0)
    `CHK(busy_sel, 1'b1)
    m_u.hold_off();
    m_u.shift(8, 8'h00, rx);
    `CHK(rx, mem[a + 16'h0001])
    m_u.hold_on();
    m_u.end_frame();
    m_u.begin_frame();
    m_u.shift(3, 8'hA0, rx);
    m_u.end_frame();
    frame(CMD_RDSR, 16'h0000, 0, 1);
    `CHK(rb[0], sr_exp(8'h00, 1'b1))
    $display("test pause done");
    t = 8'($random(seed));
    wr(CMD_WRID, 16'h0000, 1, t);
    frame(CMD_RDID, 16'h0000, 1, 1);
    `CHK(rb[0], t)
    `CHK(id_locked, 1'b0)
    wr(CMD_WRID, 16'h0400, 1, 8'h02);
    `CHK(id_locked, 1'b1)
    wr(CMD_WRID, 16'h0000, 1, ~t);
    frame(CMD_RDID, 16'h0000, 1, 1);
    `CHK(rb[0], t)
    $display("test id page done");
    conclude();
  end
endmodule
